// ===== gpib_status_string.sv
`timescale 1ns/1ps
module gpib_status_string
(
   // Clock and reset.
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   // Live interface state, already in this clock domain.
   input  wire logic       controller_i,
   input  wire logic [4:0] bus_addr_i,
   input  wire logic [1:0] addr_state_i,
   input  wire logic       srq_line_i,
   input  wire logic       service_request_set_call_i,
   input  wire logic       serial_polled_i,
   input  wire logic [6:0] err_code_i,
   input  wire logic       trigger_rx_i,
   input  wire logic       clear_rx_i,
   input  wire logic [1:0] xfer_mode_i,
   // Host request, character stream and SRQ state.
   input  wire logic       status_req_i,
   output logic            char_valid_o,
   output logic [7:0]      char_o,
   output logic            char_last_o,
   output logic            srq_state_o
);
   import status_string_pkg::*;

   typedef struct packed {
      state_t     st;
      logic [4:0] col;
      logic       chg;
      logic       srq_own;
      logic       trig;
      logic       clr;
      logic [2:0] prev_mode;
      logic       valid;
      logic [7:0] ch;
      logic       last;
      logic       srq_out;
   } regs_t;

   regs_t r, next_r;

   function automatic logic [7:0] dig(input logic [6:0] v, input logic tens);
      logic [6:0] q;
      q = v / 7'h0A;
      dig = tens ? (CH_ZERO + {1'b0, q}) : (CH_ZERO + {1'b0, v - q * 7'h0A});
   endfunction : dig

   function automatic logic [7:0] bit_char(input logic b);
      bit_char = b ? "1" : "0";
   endfunction : bit_char

   logic       srq_now;
   logic [2:0] mode_now;
   logic [6:0] addr7;
   logic [7:0] c;

   always_comb begin
      srq_now  = controller_i ? srq_line_i : r.srq_own;
      mode_now = {controller_i, addr_state_i};
      addr7    = (bus_addr_i > ADDR_MAX) ? {2'b00, ADDR_MAX} : {2'b00, bus_addr_i};
      c = CH_SPACE;
      case (r.col)
         COL_ROLE:        c = controller_i ? "C" : "P";
         COL_ADDR:        c = dig(addr7, 1'b1);
         COL_ADDR + 5'h1: c = dig(addr7, 1'b0);
         COL_CHG:         c = "G";
         COL_CHG + 5'h1:  c = bit_char(r.chg);
         COL_STATE:       c = (addr_state_i == ADDR_TALK) ? "T" :
                              (addr_state_i == ADDR_LISTEN) ? "L" : "I";
         COL_SRQ:         c = "S";
         COL_SRQ + 5'h1:  c = bit_char(srq_now);
         COL_ERR:         c = "E";
         COL_ERR + 5'h1:  c = dig(err_code_i, 1'b1);
         COL_ERR + 5'h2:  c = dig(err_code_i, 1'b0);
         COL_TRIG:        c = "T";
         COL_TRIG + 5'h1: c = bit_char(r.trig);
         COL_CLR:         c = "C";
         COL_CLR + 5'h1:  c = bit_char(r.clr);
         COL_XFER:        c = "P";
         COL_XFER + 5'h1: c = CH_ZERO + {6'h00, xfer_mode_i};
         COL_NUL:         c = CH_NUL;
         default:         c = CH_SPACE;
      endcase

      next_r = r;
      next_r.valid = 1'b0;
      next_r.last  = 1'b0;
      next_r.prev_mode = mode_now;
      // Trigger and clear flags freeze while a continuous DMA runs.
      if (xfer_mode_i != XFER_CONT) begin
         if (trigger_rx_i) next_r.trig = 1'b1;
         if (clear_rx_i) next_r.clr = 1'b1;
      end
      if (serial_polled_i) next_r.srq_own = 1'b0;
      if (service_request_set_call_i) next_r.srq_own = 1'b1;
      case (r.st)
         ST_IDLE: begin
            if (status_req_i) begin
               next_r.st  = ST_SEND;
               next_r.col = COL_ROLE;
            end
         end
         ST_SEND: begin
            next_r.valid = 1'b1;
            next_r.ch    = c;
            if (r.col == COL_NUL) begin
               next_r.last = 1'b1;
               next_r.st   = ST_IDLE;
            end else begin
               next_r.col = r.col + 5'h01;
            end
            if (r.col == COL_CHG + 5'h1) next_r.chg = 1'b0;
         end
         default: next_r.st = ST_IDLE;
      endcase
      // A change in the same cycle as the read wins over the clear.
      if (mode_now != r.prev_mode) next_r.chg = 1'b1;
      next_r.srq_out = srq_now;
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         r <= '{st: ST_IDLE, ch: CH_NUL, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign char_valid_o = r.valid;
   assign char_o       = r.ch;
   assign char_last_o  = r.last;
   assign srq_state_o  = r.srq_out;

   property p_role;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_ROLE) |=> (char_o == ($past(controller_i) ? "C" : "P"));
   endproperty
   a_role: assert property (p_role) else $error("Role character wrong.");

   property p_len;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_IDLE && status_req_i) |=> ##26 (char_last_o && char_o == CH_NUL);
   endproperty
   a_len: assert property (p_len) else $error("Terminator not at end.");

   property p_chg_clear;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_CHG + 5'h1 && mode_now == r.prev_mode) |=> !r.chg;
   endproperty
   a_chg_clear: assert property (p_chg_clear) else $error("Change flag not cleared.");

   property p_chg_set;
      @(posedge mclk_i) disable iff (!rstn_i)
      (mode_now != r.prev_mode) |=> r.chg;
   endproperty
   a_chg_set: assert property (p_chg_set) else $error("Change flag not set.");

   property p_srq_ctl;
      @(posedge mclk_i) disable iff (!rstn_i)
      controller_i |=> (srq_state_o == $past(srq_line_i));
   endproperty
   a_srq_ctl: assert property (p_srq_ctl) else $error("Controller SRQ mismatch.");

   property p_poll;
      @(posedge mclk_i) disable iff (!rstn_i)
      (serial_polled_i && !service_request_set_call_i) |=> !r.srq_own;
   endproperty
   a_poll: assert property (p_poll) else $error("Poll did not clear SRQ.");

   property p_trig_freeze;
      @(posedge mclk_i) disable iff (!rstn_i)
      (xfer_mode_i == XFER_CONT) |=> (r.trig == $past(r.trig) && r.clr == $past(r.clr));
   endproperty
   a_trig_freeze: assert property (p_trig_freeze) else $error("Flags moved during DMA.");

   property p_err;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_ERR) |=> (char_o == "E");
   endproperty
   a_err: assert property (p_err) else $error("Error column wrong.");

   property p_sep;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && (r.col == COL_ROLE + 5'h1 || r.col == COL_ADDR + 5'h2 || r.col == COL_CHG + 5'h2 ||
                           r.col == COL_STATE + 5'h1 || r.col == COL_SRQ + 5'h2 || r.col == COL_ERR + 5'h3 ||
                           r.col == COL_TRIG + 5'h2 || r.col == COL_CLR + 5'h2)) |=> (char_o == CH_SPACE);
   endproperty
   a_sep: assert property (p_sep) else $error("Separator column wrong.");

   property p_addr_dig;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_ADDR && bus_addr_i <= ADDR_MAX) |=>
         (char_o == 8'(CH_ZERO + $past(bus_addr_i) / 5'h0A));
   endproperty
   a_addr_dig: assert property (p_addr_dig) else $error("Address tens digit wrong.");

   property p_state_char;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_STATE) |=>
         (char_o == (($past(addr_state_i) == ADDR_TALK) ? "T" : ($past(addr_state_i) == ADDR_LISTEN) ? "L" : "I"));
   endproperty
   a_state_char: assert property (p_state_char) else $error("Addressed state column wrong.");

   property p_srq_char;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_SRQ + 5'h1 && controller_i) |=>
         (char_o == ($past(srq_line_i) ? "1" : "0"));
   endproperty
   a_srq_char: assert property (p_srq_char) else $error("Service request digit wrong.");

   property p_xfer_char;
      @(posedge mclk_i) disable iff (!rstn_i)
      (r.st == ST_SEND && r.col == COL_XFER + 5'h1) |=> (char_o == (CH_ZERO + {6'h00, $past(xfer_mode_i)}));
   endproperty
   a_xfer_char: assert property (p_xfer_char) else $error("Transfer digit wrong.");

   property p_stream;
      @(posedge mclk_i) disable iff (!rstn_i)
      (char_valid_o && !char_last_o) |=> char_valid_o;
   endproperty
   a_stream: assert property (p_stream) else $error("Character stream broke early.");
endmodule : gpib_status_string

// ===== status_string_pkg.sv
package status_string_pkg;
   localparam int unsigned STR_LEN        = 26;
   localparam logic [4:0]  COL_ROLE       = 5'h00;
   localparam logic [4:0]  COL_ADDR       = 5'h02;
   localparam logic [4:0]  COL_CHG        = 5'h05;
   localparam logic [4:0]  COL_STATE      = 5'h08;
   localparam logic [4:0]  COL_SRQ        = 5'h0A;
   localparam logic [4:0]  COL_ERR        = 5'h0D;
   localparam logic [4:0]  COL_TRIG       = 5'h11;
   localparam logic [4:0]  COL_CLR        = 5'h14;
   localparam logic [4:0]  COL_XFER       = 5'h17;
   localparam logic [4:0]  COL_NUL        = 5'h19;
   localparam logic [4:0]  ADDR_MAX       = 5'h1E;
   localparam logic [7:0]  CH_SPACE       = 8'h20;
   localparam logic [7:0]  CH_ZERO        = 8'h30;
   localparam logic [7:0]  CH_NUL         = 8'h00;
   localparam logic [1:0]  ADDR_TALK      = 2'h1;
   localparam logic [1:0]  ADDR_LISTEN    = 2'h2;
   localparam logic [1:0]  XFER_CONT      = 2'h1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } state_t;
endpackage : status_string_pkg

// ===== bus_side_model.sv
`timescale 1ns/1ps
module bus_side_model (
   // Clock.
   input  wire logic       clk_i,
   // Wanted bus state: role, addressed state, SRQ, trigger, clear, poll.
   input  wire logic [6:0] cmd_i,
   // Bus state as the board sees it.
   output logic [6:0]      bus_o
);
   // Bus events land one cycle late, just after the edge, as a real bus would.
   always @(posedge clk_i) begin
      bus_o <= #5 cmd_i;
   end
endmodule : bus_side_model

// ===== gpib_status_string_test.sv
`timescale 1ns/1ps
module gpib_status_string_test;
   import status_string_pkg::*;
   logic       mclk_i   = 1'b0;
   logic       rstn_i   = 1'b0;
   logic       srq_call = 1'b0;
   logic       req      = 1'b0;
   logic [4:0] addr     = 5'h05;
   logic [6:0] err      = 7'h00;
   logic [1:0] xfer     = 2'h0;
   logic [6:0] cmd      = 7'h00;
   logic [6:0] bus;
   logic       valid;
   logic       last;
   logic [7:0] ch;
   logic       srq;
   logic [7:0] stat_buf [75];
   int         errors   = 0;
   int         checks   = 0;

   bus_side_model model (.clk_i(mclk_i), .cmd_i(cmd), .bus_o(bus));
   gpib_status_string dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .controller_i(bus[6]), .bus_addr_i(addr),
      .addr_state_i(bus[5:4]), .srq_line_i(bus[3]), .service_request_set_call_i(srq_call),
      .serial_polled_i(bus[0]), .err_code_i(err), .trigger_rx_i(bus[2]), .clear_rx_i(bus[1]),
      .xfer_mode_i(xfer), .status_req_i(req), .char_valid_o(valid), .char_o(ch),
      .char_last_o(last), .srq_state_o(srq));

   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   task step;
      @(posedge mclk_i);
      #5;
   endtask : step

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Reads one whole string; a missing first character, or one more than 10 cycles late, fails it.
   task rd(input string s);
      int n;
      req = 1'b1;
      step;
      req = 1'b0;
      n = 0;
      while (valid !== 1'b1 && n < 10) begin
         step;
         n++;
      end
      for (int i = 0; i < STR_LEN; i++) begin
         stat_buf[i] = ch;
         chk(stat_buf[i], (i < STR_LEN - 1) ? s[i] : CH_NUL);
         chk({7'h00, last}, {7'h00, i == STR_LEN - 1});
         chk({7'h00, valid}, 8'h01);
         step;
      end
      chk({7'h00, valid}, 8'h00);
   endtask : rd

   task pulse(input int b);
      cmd[b] = 1'b1;
      step;
      cmd[b] = 1'b0;
      step;
   endtask : pulse

   task test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   initial begin
      #100000;
      errors++;
      test_done;
   end

   initial begin
      repeat (5) step;
      rstn_i = 1'b1;
      rd("P 05 G0 I S0 E00 T0 C0 P0");
      cmd = 7'h58;
      addr = 5'h1E;
      err = 7'h2A;
      xfer = 2'h2;
      step;
      step;
      chk({7'h00, srq}, 8'h01);
      rd("C 30 G1 T S1 E42 T0 C0 P2");
      rd("C 30 G0 T S1 E42 T0 C0 P2");
      cmd = 7'h20;
      addr = 5'h00;
      err = 7'h00;
      xfer = 2'h0;
      srq_call = 1'b1;
      step;
      srq_call = 1'b0;
      pulse(2);
      pulse(1);
      chk({7'h00, srq}, 8'h01);
      rd("P 00 G1 L S1 E00 T1 C1 P0");
      pulse(0);
      xfer = 2'h1;
      step;
      chk({7'h00, srq}, 8'h00);
      step;
      rd("P 00 G0 L S0 E00 T1 C1 P1");
      cmd = 7'h00;
      rstn_i = 1'b0;
      step;
      step;
      rstn_i = 1'b1;
      pulse(2);
      pulse(1);
      rd("P 00 G0 I S0 E00 T0 C0 P1");
      test_done;
   end
endmodule : gpib_status_string_test
